// *** logic/switch_vendor_csr_refclk_buffer.sv ***
// vendor csr bank of the upstream port and strap-controlled reference clock fan-out
`timescale 1ns/1ps
// Function
// - five per-port completion flow enables, reset zero
// - x1 threshold low half, reset 0080
// - x2 threshold high half, reset 0200
// - x4 threshold low half, upper reserved
// - power saving disable bit, preloadable
// - led mode select, enable, mode bits
// - strap low enables buffer, seven pairs
// - strap high disables buffer, board clocks core
// - clock buffer control bits gate pairs
// - side channel select resets to smbus
module switch_vendor_csr_refclk_buffer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire vendor_csr_pkg::cfg_req_s cfg_req,
  input wire vendor_csr_pkg::preload_s preload,
  input wire logic refclk_fanout_powerdown_strap,
  output logic cfg_ack_r,
  output logic [31:0] cfg_rdata_r,
  output logic [5:1] completion_traffic_flow_en_r,
  output logic [15:0] threshold_x1_r,
  output logic [15:0] threshold_x2_r,
  output logic [15:0] threshold_x4_r,
  output logic power_saving_disable_r,
  output logic [4:0] led_mode_select_r,
  output logic led_enable_r,
  output logic led_mode_r,
  output logic smbus_select_r,
  output logic refclk_buffer_enabled_r,
  output logic external_core_clock_required_r,
  output logic [7:1] fanout_pair_enable_r
);
  // ****************************************
  // byte-lane merge
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // ****************************************
  // current images, reserved bits zero
  // ****************************************
  logic [7:0] clkbuf_ctrl_r;
  wire logic [31:0] img_flow = {26'h0, completion_traffic_flow_en_r, 1'b0};
  wire logic [31:0] img_thr_n = {threshold_x2_r, threshold_x1_r};
  wire logic [31:0] img_thr_w = {16'h0, threshold_x4_r};
  wire logic [31:0] img_psave = {31'h0, power_saving_disable_r};
  wire logic [31:0] img_led = {25'h0, led_mode_r, led_enable_r, led_mode_select_r};
  wire logic [31:0] img_oper = {8'h00, clkbuf_ctrl_r, 16'h0000};
  wire logic [31:0] img_side = {31'h0, smbus_select_r};

  // ****************************************
  // write source select
  // ****************************************
  // software wins over a colliding preload; preload is meant to finish first
  wire logic sw_wr = cfg_req.valid & cfg_req.write;
  wire logic wr_any = sw_wr | preload.valid;
  wire logic [11:0] wr_addr = sw_wr ? cfg_req.addr : preload.addr;
  wire logic [31:0] wr_data = sw_wr ? cfg_req.wdata : preload.data;
  wire logic [3:0] wr_be = sw_wr ? cfg_req.byte_en : 4'hf;

  // ****************************************
  // address hits
  // ****************************************
  // preload shares this decode, so it can reach every register
  wire logic hit_flow = wr_any && wr_addr == vendor_csr_pkg::COMPLETION_FLOW_ENABLE_OFS;
  wire logic hit_thr_n = wr_any && wr_addr == vendor_csr_pkg::COMPLETION_THRESHOLD_NARROW_OFS;
  wire logic hit_thr_w = wr_any && wr_addr == vendor_csr_pkg::COMPLETION_THRESHOLD_WIDE_OFS;
  wire logic hit_psave = wr_any && wr_addr == vendor_csr_pkg::POWER_SAVING_DISABLE_OFS;
  wire logic hit_led = wr_any && wr_addr == vendor_csr_pkg::LED_DISPLAY_CONTROL_OFS;
  wire logic hit_oper = wr_any && wr_addr == vendor_csr_pkg::OPER_MODE_OFS;
  wire logic hit_side = wr_any && wr_addr == vendor_csr_pkg::SIDE_CHANNEL_OFS;

  // ****************************************
  // merged write values
  // ****************************************
  // merging onto the read image keeps lanes without byte enable at their current value
  wire logic [31:0] new_flow = merge(img_flow, wr_data, wr_be);
  wire logic [31:0] new_thr_n = merge(img_thr_n, wr_data, wr_be);
  wire logic [31:0] new_thr_w = merge(img_thr_w, wr_data, wr_be);
  wire logic [31:0] new_psave = merge(img_psave, wr_data, wr_be);
  wire logic [31:0] new_led = merge(img_led, wr_data, wr_be);
  wire logic [31:0] new_oper = merge(img_oper, wr_data, wr_be);
  wire logic [31:0] new_side = merge(img_side, wr_data, wr_be);

  // ****************************************
  // read decode
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    unique case (cfg_req.addr)
      vendor_csr_pkg::COMPLETION_FLOW_ENABLE_OFS: rd_mux = img_flow;
      vendor_csr_pkg::COMPLETION_THRESHOLD_NARROW_OFS: rd_mux = img_thr_n;
      vendor_csr_pkg::COMPLETION_THRESHOLD_WIDE_OFS: rd_mux = img_thr_w;
      vendor_csr_pkg::POWER_SAVING_DISABLE_OFS: rd_mux = img_psave;
      vendor_csr_pkg::LED_DISPLAY_CONTROL_OFS: rd_mux = img_led;
      vendor_csr_pkg::OPER_MODE_OFS: rd_mux = img_oper;
      vendor_csr_pkg::SIDE_CHANNEL_OFS: rd_mux = img_side;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // answer path
  // ****************************************
  // ack and data stand one cycle only; a write answers with zero data
  wire logic cfg_ack_nxt = cfg_req.valid;
  wire logic [31:0] cfg_rdata_nxt = (cfg_req.valid && !cfg_req.write) ? rd_mux : 32'h0000_0000;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_ack_r <= 1'b0;
    end else begin
      cfg_ack_r <= cfg_ack_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_rdata_r <= 32'h0000_0000;
    end else begin
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  // ****************************************
  // completion flow enables
  // ****************************************
  wire logic [5:1] completion_traffic_flow_en_nxt = hit_flow ?
    new_flow[vendor_csr_pkg::FLOW_EN_MSB:vendor_csr_pkg::FLOW_EN_LSB] :
    completion_traffic_flow_en_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      completion_traffic_flow_en_r <= vendor_csr_pkg::FLOW_EN_RST;
    end else begin
      completion_traffic_flow_en_r <= completion_traffic_flow_en_nxt;
    end
  end

  // ****************************************
  // x1 and x2 thresholds, one word
  // ****************************************
  // lanes 1:0 carry x1 and lanes 3:2 carry x2, so either half can move alone
  wire logic [15:0] threshold_x1_nxt = hit_thr_n ?
    new_thr_n[vendor_csr_pkg::THR_X1_LSB +: vendor_csr_pkg::THR_W] : threshold_x1_r;
  wire logic [15:0] threshold_x2_nxt = hit_thr_n ?
    new_thr_n[vendor_csr_pkg::THR_X2_LSB +: vendor_csr_pkg::THR_W] : threshold_x2_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      threshold_x1_r <= vendor_csr_pkg::THR_X1_RST;
    end else begin
      threshold_x1_r <= threshold_x1_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      threshold_x2_r <= vendor_csr_pkg::THR_X2_RST;
    end else begin
      threshold_x2_r <= threshold_x2_nxt;
    end
  end

  // ****************************************
  // x4 threshold, upper half reserved
  // ****************************************
  // writes to the reserved upper lanes fall away in the slice
  wire logic [15:0] threshold_x4_nxt = hit_thr_w ?
    new_thr_w[vendor_csr_pkg::THR_X1_LSB +: vendor_csr_pkg::THR_W] : threshold_x4_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      threshold_x4_r <= vendor_csr_pkg::THR_X4_RST;
    end else begin
      threshold_x4_r <= threshold_x4_nxt;
    end
  end

  // ****************************************
  // power saving disable
  // ****************************************
  // a preload of this word lands exactly like a software write
  wire logic power_saving_disable_nxt = hit_psave ? new_psave[0] : power_saving_disable_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_saving_disable_r <= vendor_csr_pkg::PSAVE_DIS_RST;
    end else begin
      power_saving_disable_r <= power_saving_disable_nxt;
    end
  end

  // ****************************************
  // led display control
  // ****************************************
  wire logic [4:0] led_mode_select_nxt = hit_led ?
    new_led[vendor_csr_pkg::LED_MODE_SEL_LSB +: vendor_csr_pkg::LED_MODE_SEL_W] :
    led_mode_select_r;
  wire logic led_enable_nxt =
    hit_led ? new_led[vendor_csr_pkg::LED_ENABLE_BIT] : led_enable_r;
  wire logic led_mode_nxt =
    hit_led ? new_led[vendor_csr_pkg::LED_MODE_BIT] : led_mode_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {led_mode_r, led_enable_r, led_mode_select_r} <= vendor_csr_pkg::LED_RST;
    end else begin
      led_mode_select_r <= led_mode_select_nxt;
      led_enable_r <= led_enable_nxt;
      led_mode_r <= led_mode_nxt;
    end
  end

  // ****************************************
  // operation mode: clock buffer control
  // ****************************************
  // only bits 23:16 of this word exist here; the rest reads zero
  wire logic [7:0] clkbuf_ctrl_nxt = hit_oper ?
    new_oper[vendor_csr_pkg::CLKBUF_CTRL_LSB +: vendor_csr_pkg::CLKBUF_CTRL_W] :
    clkbuf_ctrl_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clkbuf_ctrl_r <= vendor_csr_pkg::CLKBUF_CTRL_RST;
    end else begin
      clkbuf_ctrl_r <= clkbuf_ctrl_nxt;
    end
  end

  // ****************************************
  // side channel select
  // ****************************************
  // only the select bit is kept; the other bits of this word read zero
  wire logic smbus_select_nxt = hit_side ? new_side[0] : smbus_select_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      smbus_select_r <= vendor_csr_pkg::SMBUS_EN_RST;
    end else begin
      smbus_select_r <= smbus_select_nxt;
    end
  end

  // ****************************************
  // strap capture
  // ****************************************
  // strap is a pin: two flops first, then caught once after reset release
  // later strap moves are ignored; only a new reset takes another look
  logic strap_meta_r;
  logic strap_sync_r;
  logic strap_taken_r;
  always_ff @(posedge ref_clk) begin
    strap_meta_r <= refclk_fanout_powerdown_strap;
    strap_sync_r <= strap_meta_r;
  end

  wire logic capture_now = !strap_taken_r;
  wire logic refclk_buffer_enabled_nxt =
    capture_now ? ~strap_sync_r : refclk_buffer_enabled_r;
  wire logic external_core_clock_required_nxt =
    capture_now ? strap_sync_r : external_core_clock_required_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_taken_r <= 1'b0;
    end else begin
      strap_taken_r <= 1'b1;
    end
  end

  // ****************************************
  // buffer state
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      refclk_buffer_enabled_r <= 1'b0;
    end else begin
      refclk_buffer_enabled_r <= refclk_buffer_enabled_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      external_core_clock_required_r <= 1'b0;
    end else begin
      external_core_clock_required_r <= external_core_clock_required_nxt;
    end
  end

  // ****************************************
  // fan-out pair gating
  // ****************************************
  // a set control bit turns its pair off; bit 16 is unused, bits 23:17 map to pairs 7:1
  // the pairs themselves are analog; only their enables are made here
  wire logic [7:1] fanout_pair_enable_nxt;
  for (genvar k = 1; k <= vendor_csr_pkg::FANOUT_PAIRS; k++) begin : g_pair
    assign fanout_pair_enable_nxt[k] = refclk_buffer_enabled_r & ~clkbuf_ctrl_r[k];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fanout_pair_enable_r <= 7'h00;
    end else begin
      fanout_pair_enable_r <= fanout_pair_enable_nxt;
    end
  end
endmodule : switch_vendor_csr_refclk_buffer

// *** logic/vendor_csr_pkg.sv ***
// package: offsets, field layout, reset values and request carrier of the vendor csr bank
package vendor_csr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OPER_MODE_OFS = 12'h098;
  localparam logic [11:0] SIDE_CHANNEL_OFS = 12'h344;
  localparam logic [11:0] COMPLETION_FLOW_ENABLE_OFS = 12'h350;
  localparam logic [11:0] COMPLETION_THRESHOLD_NARROW_OFS = 12'h354;
  localparam logic [11:0] COMPLETION_THRESHOLD_WIDE_OFS = 12'h358;
  localparam logic [11:0] POWER_SAVING_DISABLE_OFS = 12'h360;
  localparam logic [11:0] LED_DISPLAY_CONTROL_OFS = 12'h364;
  // ****************************************
  // field layout
  // ****************************************
  localparam int FLOW_EN_LSB = 1;
  localparam int FLOW_EN_MSB = 5;
  localparam int THR_X1_LSB = 0;
  localparam int THR_X2_LSB = 16;
  localparam int THR_W = 16;
  localparam int LED_MODE_SEL_LSB = 0;
  localparam int LED_MODE_SEL_W = 5;
  localparam int LED_ENABLE_BIT = 5;
  localparam int LED_MODE_BIT = 6;
  localparam int CLKBUF_CTRL_LSB = 16;
  localparam int CLKBUF_CTRL_W = 8;
  localparam int FANOUT_PAIRS = 7;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0] FLOW_EN_RST = 5'h00;
  localparam logic [15:0] THR_X1_RST = 16'h0080;
  localparam logic [15:0] THR_X2_RST = 16'h0200;
  localparam logic [15:0] THR_X4_RST = 16'h0800;
  localparam logic PSAVE_DIS_RST = 1'b0;
  localparam logic [6:0] LED_RST = 7'h00;
  localparam logic [7:0] CLKBUF_CTRL_RST = 8'h00;
  localparam logic SMBUS_EN_RST = 1'b1;
  // ****************************************
  // request carrier
  // ****************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_s;
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [31:0] data;
  } preload_s;
endpackage : vendor_csr_pkg

// *** test/test_switch_vendor_csr_refclk_buffer.sv ***
// testbench: config reads and writes, preload and strap capture
`timescale 1ns/1ps
module test_switch_vendor_csr_refclk_buffer;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b0;
  vendor_csr_pkg::cfg_req_s cfg_req = '0;
  vendor_csr_pkg::preload_s preload = '0;
  logic ack, psave, smb, buf_en, ext, led_en, led_md;
  logic [15:0] x1, x2, x4;
  logic [4:0] led_sel;
  logic [31:0] rdata, rd;
  logic [5:1] flow;
  logic [7:1] pairs;
  int fail_count = 0;
  int checks_done = 0;
  logic [11:0] ofs [8] = '{12'h350, 12'h354, 12'h358, 12'h360, 12'h364, 12'h344, 12'h098,
    12'h100};
  logic [31:0] rst_v [8] = '{32'h0, 32'h02000080, 32'h800, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  logic [31:0] ones_v [8] = '{32'h3e, '1, 32'hffff, 32'h1, 32'h7f, 32'h1, 32'hff0000, 32'h0};
  always #50 ref_clk = ~ref_clk;
  switch_vendor_csr_refclk_buffer switch_vendor_csr_refclk_buffer_i (
    .ref_clk, .reset, .cfg_req, .preload, .refclk_fanout_powerdown_strap(strap),
    .cfg_ack_r(ack), .cfg_rdata_r(rdata), .completion_traffic_flow_en_r(flow),
    .threshold_x1_r(x1), .threshold_x2_r(x2), .threshold_x4_r(x4),
    .power_saving_disable_r(psave), .led_mode_select_r(led_sel), .led_enable_r(led_en),
    .led_mode_r(led_md), .smbus_select_r(smb),
    .refclk_buffer_enabled_r(buf_en), .external_core_clock_required_r(ext),
    .fanout_pair_enable_r(pairs)
  );
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // one-cycle request pulse; ack and data stand only in the cycle after
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] be = 4'hf);
    @(posedge ref_clk);
    cfg_req <= '{1'b1, w, a, be, d};
    @(posedge ref_clk);
    cfg_req.valid <= 1'b0;
    #1;
    check("ack", 32'h1, 32'(ack));
    rd = rdata;
  endtask : access
  // strap held for the whole reset so the synchroniser settles first
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    strap <= s;
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : do_reset
  initial begin
    do_reset(1'b0);
    check("pairs", 32'h7f, 32'(pairs));
    check("ext", 32'h0, 32'(ext));
    check("buf_en", 32'h1, 32'(buf_en));
    check("x1", 32'h0080, 32'(x1));
    check("x2", 32'h0200, 32'(x2));
    check("x4", 32'h0800, 32'(x4));
    check("led", 32'h0, 32'({led_md, led_en, led_sel}));
    for (int i = 0; i < 8; i++) begin
      access(1'b0, ofs[i], 32'h0);
      check("reset value", rst_v[i], rd);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      access(1'b1, ofs[i], '1);
      access(1'b0, ofs[i], 32'h0);
      check("ones readback", ones_v[i], rd);
    end
    check("flow", 32'h1f, 32'(flow));
    check("x1", 32'hffff, 32'(x1));
    check("x2", 32'hffff, 32'(x2));
    check("x4", 32'hffff, 32'(x4));
    check("psave", 32'h1, 32'(psave));
    check("led", 32'h7f, 32'({led_md, led_en, led_sel}));
    check("pairs gated", 32'h0, 32'(pairs));
    access(1'b1, 12'h354, 32'h5555_1234, 4'h3);
    check("x1 lanes", 32'h1234, 32'(x1));
    check("x2 kept", 32'hffff, 32'(x2));
    $display("test write ones done");
    @(posedge ref_clk);
    preload <= '{1'b1, 12'h360, 32'h0};
    @(posedge ref_clk);
    preload.valid <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("psave", 32'h0, 32'(psave));
    access(1'b1, 12'h344, 32'h0);
    check("smbus", 32'h0, 32'(smb));
    access(1'b1, 12'h098, 32'h00020000);
    @(posedge ref_clk);
    #1;
    check("pairs", 32'h7e, 32'(pairs));
    $display("test preload and pairs done");
    do_reset(1'b1);
    check("buf_en", 32'h0, 32'(buf_en));
    check("ext", 32'h1, 32'(ext));
    check("pairs off", 32'h0, 32'(pairs));
    check("x4 after reset", 32'h0800, 32'(x4));
    check("smbus after reset", 32'h1, 32'(smb));
    $display("test strap high done");
    wrap_up();
  end
endmodule : test_switch_vendor_csr_refclk_buffer

// *** test/vendor_csr_assertions.sv ***
// checker: port assertions for the vendor csr bank and clock fan-out
`timescale 1ns/1ps
module vendor_csr_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire vendor_csr_pkg::cfg_req_s cfg_req,
  input wire vendor_csr_pkg::preload_s preload,
  input wire logic [31:0] cfg_rdata_r,
  input wire logic [5:1] completion_traffic_flow_en_r,
  input wire logic [15:0] threshold_x1_r,
  input wire logic [15:0] threshold_x2_r,
  input wire logic [15:0] threshold_x4_r,
  input wire logic power_saving_disable_r,
  input wire logic [4:0] led_mode_select_r,
  input wire logic led_enable_r,
  input wire logic led_mode_r,
  input wire logic smbus_select_r,
  input wire logic refclk_buffer_enabled_r,
  input wire logic external_core_clock_required_r,
  input wire logic [7:1] fanout_pair_enable_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // properties
  // ****************************************
  wire logic wr = cfg_req.valid & cfg_req.write;
  wire logic [11:0] a = cfg_req.addr;
  wire logic [3:0] be = cfg_req.byte_en;
  wire logic [31:0] d = cfg_req.wdata;
  property p_flow;
    wr && a == 12'h350 && be[0] |=> completion_traffic_flow_en_r == $past(d[5:1]);
  endproperty
  a_flow: assert property (p_flow) else $error("flow enables not written");
  property p_thr;
    wr && a == 12'h354 && be == 4'hf |=> {threshold_x2_r, threshold_x1_r} == $past(d);
  endproperty
  a_thr: assert property (p_thr) else $error("narrow thresholds not written");
  // read of the wide threshold must show zeros in the reserved half
  property p_wide;
    cfg_req.valid && !cfg_req.write && a == 12'h358 |=>
      cfg_rdata_r == {16'h0, $past(threshold_x4_r)};
  endproperty
  a_wide: assert property (p_wide) else $error("wide threshold read wrong");
  property p_psave;
    preload.valid && preload.addr == 12'h360 && !wr |=>
      power_saving_disable_r == $past(preload.data[0]);
  endproperty
  a_psave: assert property (p_psave) else $error("preload of power saving lost");
  property p_led;
    wr && a == 12'h364 && be[0] |=>
      {led_mode_r, led_enable_r, led_mode_select_r} == $past(d[6:0]);
  endproperty
  a_led: assert property (p_led) else $error("led control not written");
  property p_smb;
    wr && a == 12'h344 && be[0] |=> smbus_select_r == $past(d[0]);
  endproperty
  a_smb: assert property (p_smb) else $error("side channel select not written");
  property p_strap;
    !$past(reset, 2) |-> refclk_buffer_enabled_r != external_core_clock_required_r;
  endproperty
  a_strap: assert property (p_strap) else $error("buffer state not exclusive");
  // pair k follows the inverse of control bit 16+k, one cycle after storage
  property p_pairs;
    wr && a == 12'h098 && be[2] && refclk_buffer_enabled_r |=> ##1
      fanout_pair_enable_r == ~$past(d[23:17], 2);
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair enables wrong");
  // pairs stay dark whenever the buffer is off
  property p_pairs_off;
    !refclk_buffer_enabled_r |-> fanout_pair_enable_r == 7'h00;
  endproperty
  a_pairs_off: assert property (p_pairs_off) else $error("pairs on with buffer off");
  c_write: cover property (wr);
  c_preload: cover property (preload.valid);
  c_pairs: cover property (wr && a == 12'h098);
endmodule : vendor_csr_checker
bind switch_vendor_csr_refclk_buffer vendor_csr_checker vendor_csr_checker_i (
  .ref_clk, .reset, .cfg_req, .preload, .cfg_rdata_r, .completion_traffic_flow_en_r,
  .threshold_x1_r, .threshold_x2_r, .threshold_x4_r, .power_saving_disable_r,
  .led_mode_select_r, .led_enable_r, .led_mode_r, .smbus_select_r, .refclk_buffer_enabled_r,
  .external_core_clock_required_r, .fanout_pair_enable_r
);
